/* File: rtl/supervisor_consts.vh */
// timing constants for the processor supervisor
`ifndef SUPERVISOR_CONSTS_VH
`define SUPERVISOR_CONSTS_VH
`define CLOCK_HZ          20000000
`define RESET_STRETCH_MS  200
`define WATCHDOG_TIME_MS  1600
`define RESET_STRETCH_CYCLES ((`CLOCK_HZ / 1000) * `RESET_STRETCH_MS)
`define WATCHDOG_CYCLES      ((`CLOCK_HZ / 1000) * `WATCHDOG_TIME_MS)
`define SYNC_STAGES       2
`endif

/* File: rtl/input_sync.v */
// two-stage synchroniser for a group of asynchronous level inputs
`timescale 1ns/1ps
module input_sync #(
  parameter WIDTH = 4
) (
  // clock and reset
  input  wire             clock,
  input  wire             sys_rst,
  // asynchronous levels and their synchronised copies
  input  wire [WIDTH-1:0] async_in,
  input  wire [WIDTH-1:0] reset_value,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // reset value is a constant from the instantiating module
  always @(posedge clock) begin
    if (sys_rst) begin
      stage1   <= reset_value;
      sync_out <= reset_value;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

/* File: rtl/cycle_timer.v */
// restartable cycle counter that flags when a count has elapsed
`timescale 1ns/1ps
module cycle_timer #(
  parameter WIDTH = 26,
  parameter COUNT = 4000000
) (
  // clock and reset
  input  wire clock,
  input  wire sys_rst,
  // control and status
  input  wire clear,
  output reg  expired
);

  localparam [31:0]      LAST_WORD = COUNT - 1;
  localparam [WIDTH-1:0] LAST      = LAST_WORD[WIDTH-1:0];

  reg [WIDTH-1:0] count;

  always @(posedge clock) begin
    if (sys_rst || clear) begin
      count   <= {WIDTH{1'b0}};
      expired <= 1'b0;
    end else if (count == LAST) begin
      expired <= 1'b1;
    end else begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule

/* File: rtl/cpu_supervisor_reset_watchdog.v */
// processor supervisor: stretched reset, watchdog and power-fail flag
//
// Operation
// - reset held low while supply is low
// - reset stays low 200 ms after recovery
// - active-high reset is complement of low
// - manual reset low asserts reset, debounced
// - no kick within timeout drives timeout low
// - any kick edge restarts watchdog count
// - reset clears watchdog; timing starts after release
// - low supply forces timeout output low
// - floating kick input disables the watchdog
// - power-fail flag low when sense low
// - power-fail flag independent of reset logic
// - reset stretched after manual reset release too
// - timeout output stays low until cleared
// - watchdog timeout alone never asserts reset
`timescale 1ns/1ps
`include "supervisor_consts.vh"
module cpu_supervisor_reset_watchdog #(
  parameter RESET_CYCLES    = `RESET_STRETCH_CYCLES,
  parameter WATCHDOG_CYCLES = `WATCHDOG_CYCLES,
  parameter TIMER_WIDTH     = 26
) (
  // clock and reset
  input  wire clock,
  input  wire sys_rst,
  // supply and manual reset
  input  wire supply_low,
  input  wire manual_reset_n,
  // watchdog
  input  wire watchdog_kick_in,
  input  wire watchdog_kick_float,
  output reg  watchdog_timeout_n,
  // power-fail comparator result
  input  wire power_fail_sense_in,
  // processor resets and flag
  output reg  cpu_reset_n,
  output reg  cpu_reset,
  output reg  power_fail_flag_n
);

  ////////////////////////////////////////////////////////////////////////
  // synchroniser lane map

  localparam LANES       = 5;
  localparam LANE_SUPPLY = 4;
  localparam LANE_MANUAL = 3;
  localparam LANE_KICK   = 2;
  localparam LANE_FLOAT  = 1;
  localparam LANE_SENSE  = 0;

  // supply held low, manual released, kick low, watchdog off, sense low
  localparam [LANES-1:0] LANE_RESET = 5'h1a;

  ////////////////////////////////////////////////////////////////////////
  // state codes

  // reset sequencer
  localparam [2:0] RST_HOLD    = 3'h1;
  localparam [2:0] RST_STRETCH = 3'h2;
  localparam [2:0] RST_RUN     = 3'h4;

  // watchdog
  localparam [2:0] WD_OFF      = 3'h1;
  localparam [2:0] WD_COUNT    = 3'h2;
  localparam [2:0] WD_EXPIRED  = 3'h4;

  ////////////////////////////////////////////////////////////////////////
  // state legality

  // a corrupted state word sends its machine back to the safe state
  function legal_state;
    input [2:0] state;
    begin
      case (state)
        3'h1: begin
          legal_state = 1'b1;
        end
        3'h2: begin
          legal_state = 1'b1;
        end
        3'h4: begin
          legal_state = 1'b1;
        end
        default: begin
          legal_state = 1'b0;
        end
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers

  wire [LANES-1:0] raw_in;
  wire [LANES-1:0] sync_in;
  wire             s_supply_low;
  wire             s_manual_n;
  wire             s_kick;
  wire             s_float;
  wire             s_sense;

  assign raw_in[LANE_SUPPLY] = supply_low;
  assign raw_in[LANE_MANUAL] = manual_reset_n;
  assign raw_in[LANE_KICK]   = watchdog_kick_in;
  assign raw_in[LANE_FLOAT]  = watchdog_kick_float;
  assign raw_in[LANE_SENSE]  = power_fail_sense_in;

  genvar lane;

  generate
    for (lane = 0; lane < LANES; lane = lane + 1) begin : g_sync
      input_sync #(
        .WIDTH       (1)
      ) u_sync (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .async_in    (raw_in[lane]),
        .reset_value (LANE_RESET[lane]),
        .sync_out    (sync_in[lane])
      );
    end
  endgenerate

  assign s_supply_low = sync_in[LANE_SUPPLY];
  assign s_manual_n   = sync_in[LANE_MANUAL];
  assign s_kick       = sync_in[LANE_KICK];
  assign s_float      = sync_in[LANE_FLOAT];
  assign s_sense      = sync_in[LANE_SENSE];

  ////////////////////////////////////////////////////////////////////////
  // reset stretch timer

  wire reset_cause;
  wire stretch_done;

  // watchdog expiry feeds nothing here; only the pin loop can reset
  assign reset_cause = s_supply_low | ~s_manual_n;

  // every bounce restarts the timer, so a bouncing button gives one pulse
  cycle_timer #(
    .WIDTH   (TIMER_WIDTH),
    .COUNT   (RESET_CYCLES)
  ) u_stretch (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clear   (reset_cause),
    .expired (stretch_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // reset sequencer

  reg [2:0] reset_state;
  reg [2:0] next_reset_state;

  always @* begin
    next_reset_state = RST_HOLD;
    if (!legal_state(reset_state)) begin
      next_reset_state = RST_HOLD;
    end else begin
      case (reset_state)
        RST_HOLD: begin
          if (reset_cause) begin
            next_reset_state = RST_HOLD;
          end else begin
            next_reset_state = RST_STRETCH;
          end
        end
        RST_STRETCH: begin
          if (reset_cause) begin
            next_reset_state = RST_HOLD;
          end else if (stretch_done) begin
            next_reset_state = RST_RUN;
          end else begin
            next_reset_state = RST_STRETCH;
          end
        end
        RST_RUN: begin
          if (reset_cause) begin
            next_reset_state = RST_HOLD;
          end else begin
            next_reset_state = RST_RUN;
          end
        end
        default: begin
          next_reset_state = RST_HOLD;
        end
      endcase
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      reset_state <= RST_HOLD;
      cpu_reset_n <= 1'b0;
      cpu_reset   <= 1'b1;
    end else begin
      reset_state <= next_reset_state;
      cpu_reset_n <= (next_reset_state == RST_RUN);
      cpu_reset   <= (next_reset_state != RST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // watchdog kick edge

  reg  kick_prev;
  wire kick_edge;

  // kick_prev resets to the synchroniser's reset level: no false edge
  always @(posedge clock) begin
    if (sys_rst) begin
      kick_prev <= 1'b0;
    end else begin
      kick_prev <= s_kick;
    end
  end

  assign kick_edge = s_kick ^ kick_prev;

  ////////////////////////////////////////////////////////////////////////
  // watchdog timer

  wire wd_hold;
  wire wd_clear;
  wire wd_expired;
  wire wd_fired;

  // counting resumes only once the reset output is released
  assign wd_hold  = ~cpu_reset_n | s_float;
  assign wd_clear = kick_edge | wd_hold;

  cycle_timer #(
    .WIDTH   (TIMER_WIDTH),
    .COUNT   (WATCHDOG_CYCLES)
  ) u_watchdog (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clear   (wd_clear),
    .expired (wd_expired)
  );

  ////////////////////////////////////////////////////////////////////////
  // watchdog sequencer

  reg [2:0] wd_state;
  reg [2:0] next_wd_state;

  always @* begin
    next_wd_state = WD_OFF;
    if (!legal_state(wd_state)) begin
      next_wd_state = WD_OFF;
    end else begin
      case (wd_state)
        WD_OFF: begin
          if (wd_hold) begin
            next_wd_state = WD_OFF;
          end else begin
            next_wd_state = WD_COUNT;
          end
        end
        WD_COUNT: begin
          if (wd_hold) begin
            next_wd_state = WD_OFF;
          end else if (kick_edge) begin
            next_wd_state = WD_COUNT;
          end else if (wd_expired) begin
            next_wd_state = WD_EXPIRED;
          end else begin
            next_wd_state = WD_COUNT;
          end
        end
        WD_EXPIRED: begin
          if (wd_hold) begin
            next_wd_state = WD_OFF;
          end else if (kick_edge) begin
            next_wd_state = WD_COUNT;
          end else begin
            next_wd_state = WD_EXPIRED;
          end
        end
        default: begin
          next_wd_state = WD_OFF;
        end
      endcase
    end
  end

  assign wd_fired = (next_wd_state == WD_EXPIRED);

  always @(posedge clock) begin
    if (sys_rst) begin
      wd_state           <= WD_OFF;
      watchdog_timeout_n <= 1'b0;
    end else begin
      wd_state           <= next_wd_state;
      // low supply overrides the watchdog whatever its state
      watchdog_timeout_n <= ~(s_supply_low | wd_fired);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-fail flag

  always @(posedge clock) begin
    if (sys_rst) begin
      power_fail_flag_n <= 1'b0;
    end else begin
      power_fail_flag_n <= s_sense;
    end
  end

endmodule

/* File: verification/sup_monitor.sv */
// assertions on the supervisor ports
`timescale 1ns/1ps
module sup_monitor (
  input wire clock, sys_rst, supply_low, manual_reset_n, watchdog_kick_in,
  input wire watchdog_kick_float, power_fail_sense_in, cpu_reset_n,
  input wire cpu_reset, watchdog_timeout_n, power_fail_flag_n
);
  reg [2:0] up = 3'h0;
  reg [7:0] calm = 8'h00;
  reg [7:0] idle = 8'h00;
  reg       kd = 1'b0;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  always @(posedge clock) begin
    up <= sys_rst ? 3'h0 : {up[1:0], 1'b1};
    calm <= sys_rst | supply_low | !manual_reset_n ? 8'h00 : calm + 8'h01;
    idle <= sys_rst | !cpu_reset_n | watchdog_kick_float |
      (watchdog_kick_in ^ kd) ? 8'h00 : idle + 8'h01;
    kd <= watchdog_kick_in;
  end
  AST_COMP: assert property (cpu_reset == !cpu_reset_n)
    else $error("reset pair mismatch");
  AST_LOW: assert property ($past(supply_low, 3) |-> !cpu_reset_n)
    else $error("reset not held on low supply");
  AST_MAN: assert property (!$past(manual_reset_n, 3) |-> !cpu_reset_n)
    else $error("manual reset ignored");
  AST_PF: assert property (&up |->
    power_fail_flag_n == $past(power_fail_sense_in, 3))
    else $error("power-fail flag wrong");
  AST_CAUSE: assert property ($fell(cpu_reset_n) |->
    $past(supply_low, 3) || !$past(manual_reset_n, 3))
    else $error("reset without cause");
  AST_HOLD: assert property ($rose(cpu_reset_n) |-> calm >= 8'h14)
    else $error("reset released early");
  AST_EXP: assert property (idle == 8'h3c |-> !watchdog_timeout_n)
    else $error("no timeout");
  AST_KICK: assert property ($fell(watchdog_timeout_n) &&
    !$past(supply_low, 3) |-> idle >= 8'h32)
    else $error("timeout early");
endmodule
bind cpu_supervisor_reset_watchdog sup_monitor i_sup_monitor (.*);

/* File: verification/cpu_model.sv */
// processor model toggling the watchdog kick line
`timescale 1ns/1ps
module cpu_model (
  input  wire clock, cpu_reset_n, enable, route, timeout_n,
  output reg  kick = 1'b0,
  output wire mr_n
);
  reg [3:0] cnt = 4'h0;
  assign mr_n = !route | timeout_n;
  always @(negedge clock) begin
    cnt <= cnt + 4'h1;
    if (enable && cpu_reset_n && &cnt) kick <= !kick;
  end
endmodule

/* File: verification/tb_top.sv */
// bench for the processor supervisor
`timescale 1ns/1ps
module tb_top;
  reg clock = 1'b0, sys_rst = 1'b1, supply_low = 1'b0, mr = 1'b1;
  reg watchdog_kick_float = 1'b0, power_fail_sense_in = 1'b1;
  reg en = 1'b1, route = 1'b0;
  wire watchdog_kick_in, mr_m, cpu_reset_n, cpu_reset;
  wire watchdog_timeout_n, power_fail_flag_n;
  wire manual_reset_n = mr & mr_m;
  wire [3:0] o = {cpu_reset_n, cpu_reset, watchdog_timeout_n,
    power_fail_flag_n};
  integer fail_count = 0, n_tests = 0, i;
  always #25 clock = ~clock;
  cpu_supervisor_reset_watchdog #(.RESET_CYCLES(20), .WATCHDOG_CYCLES(50))
    i_cpu_supervisor_reset_watchdog (.*);
  cpu_model i_cpu_model (.clock(clock), .cpu_reset_n(cpu_reset_n),
    .enable(en), .route(route), .timeout_n(watchdog_timeout_n),
    .kick(watchdog_kick_in), .mr_n(mr_m));
  task w(input integer n);
    repeat (n) @(negedge clock);
  endtask
  task chk(input [3:0] s, e);
    n_tests = n_tests + 1;
    if (s !== e) begin
      fail_count = fail_count + 1;
      $display("unexpected %0t %h %h", $time, s, e);
    end
  endtask
  task complete_run;
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task t_sup;
    supply_low = 1'b1;
    w(5);
    chk(o, 4'h5);
    supply_low = 1'b0;
    power_fail_sense_in = 1'b0;
    w(10);
    chk(o, 4'h6);
    power_fail_sense_in = 1'b1;
    w(20);
    chk(o, 4'hb);
  endtask
  task t_mr;
    power_fail_sense_in = 1'b0;
    w(4);
    chk(o, 4'ha);
    power_fail_sense_in = 1'b1;
    mr = 1'b0;
    w(2);
    mr = 1'b1;
    w(3);
    mr = 1'b0;
    w(5);
    mr = 1'b1;
    w(10);
    chk(o, 4'h7);
    w(20);
    chk(o, 4'hb);
  endtask
  task t_wd;
    w(100);
    chk(o, 4'hb);
    en = 1'b0;
    w(80);
    chk(o, 4'h9);
    w(20);
    chk(o, 4'h9);
    watchdog_kick_float = 1'b1;
    w(5);
    chk(o, 4'hb);
    w(80);
    chk(o, 4'hb);
    watchdog_kick_float = 1'b0;
    en = 1'b1;
  endtask
  task t_route;
    en = 1'b0;
    route = 1'b1;
    for (i = 0; i < 150 && cpu_reset_n; i = i + 1) w(1);
    chk({3'h0, cpu_reset_n}, 4'h0);
    en = 1'b1;
    w(60);
    chk(o, 4'hb);
    route = 1'b0;
  endtask
  initial begin
    w(20);
    sys_rst = 1'b0;
    t_sup;
    t_mr;
    t_wd;
    t_route;
    complete_run;
  end
  initial begin
    #100000;
    fail_count = fail_count + 1;
    complete_run;
  end
endmodule
